// File: rtl/trc_debounce.sv
// synchroniser, debouncer and closing-edge detector for one terminal
`timescale 1ns/10ps
module trc_debounce
	import trc_pkg::*;
#(
	parameter int CNT = DEBOUNCE_CYC
) (
	input  wire logic clk_in,
	input  wire logic rst_in,
	input  wire logic ce_in,
	input  wire logic raw_in,
	trc_term_if.filt  term
);
	logic        s1;
	logic        s2;
	logic        stable;
	logic [23:0] cnt;
	wire         differ = s2 != stable;
	wire         settled = cnt == 24'(CNT - 1);

	// a level must hold for the whole window before it is believed
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			s1 <= 1'b0;
			s2 <= 1'b0;
			stable <= 1'b0;
			cnt <= '0;
			term.closed <= 1'b0;
		end else if (ce_in) begin
			s1 <= raw_in;
			s2 <= s1;
			term.closed <= 1'b0;
			if (!differ) begin
				cnt <= '0;
			end else if (settled) begin
				cnt <= '0;
				stable <= s2;
				term.closed <= s2;
			end else begin
				cnt <= cnt + 24'h000001;
			end
		end
	end
	assign term.level = stable;
endmodule

// File: rtl/trc_pkg.sv
// constants, register map and types for the terminal run command control
package trc_pkg;
	// register byte offsets
	localparam logic [7:0] OFS_MODE     = 8'h00;
	localparam logic [7:0] OFS_STOPM    = 8'h04;
	localparam logic [7:0] OFS_STEP     = 8'h08;
	localparam logic [7:0] OFS_SLEW     = 8'h0C;
	localparam logic [7:0] OFS_FLAGS    = 8'h10;
	localparam logic [7:0] OFS_DELAY    = 8'h14;
	localparam logic [7:0] OFS_PRESET   = 8'h18;
	localparam logic [7:0] OFS_KEYPAD   = 8'h1C;
	localparam logic [7:0] OFS_STATUS   = 8'h20;
	localparam logic [7:0] OFS_FREQ     = 8'h24;
	localparam logic [7:0] OFS_SAVED    = 8'h28;
	// flags register bit positions
	localparam int FLG_DIRMEM  = 0;
	localparam int FLG_AUTORUN = 1;
	localparam int FLG_RETAIN  = 2;
	localparam int FLG_STAGE   = 3;
	// keypad command register bit positions
	localparam int KEY_RUN     = 0;
	localparam int KEY_DIR     = 1;
	localparam int KEY_UP      = 2;
	localparam int KEY_DOWN    = 3;
	// status register bit positions
	localparam int ST_RUN      = 0;
	localparam int ST_DIR      = 1;
	localparam int ST_OUT      = 2;
	localparam int ST_AUTOWAIT = 3;
	// mode codes
	localparam logic [2:0] MODE_OFF   = 3'h0;
	localparam logic [2:0] MODE_2L1   = 3'h1;
	localparam logic [2:0] MODE_2L2   = 3'h2;
	localparam logic [2:0] MODE_3L1   = 3'h3;
	localparam logic [2:0] MODE_3L2   = 3'h4;
	localparam logic [2:0] MODE_PULSE = 3'h5;
	localparam logic STOP_RAMP  = 1'h0;
	localparam logic STOP_COAST = 1'h1;
	// frequencies in 0.01 Hz units, slew in 0.01 Hz/s, delay in 0.1 s
	localparam int        FW           = 16;
	localparam logic [15:0] STEP_MIN   = 16'h0001;
	localparam logic [15:0] STEP_MAX   = 16'h00C8;
	localparam logic [15:0] STEP_RST   = 16'h0001;
	localparam logic [15:0] STANDBY_STEP = 16'h0001;
	localparam logic [15:0] SLEW_MIN   = 16'h0001;
	localparam logic [15:0] SLEW_MAX   = 16'h2710;
	localparam logic [15:0] SLEW_RST   = 16'h01F4;
	localparam logic [15:0] DELAY_MIN  = 16'h0001;
	localparam logic [15:0] DELAY_MAX  = 16'h7530;
	localparam logic [15:0] DELAY_RST  = 16'h0258;
	localparam logic [15:0] PRESET_RST = 16'h1388;
	localparam logic [15:0] RAMP_STEP  = 16'h0001;
	// timing
	localparam int CLK_HZ        = 20000000;
	localparam int DEBOUNCE_US   = 5000;
	localparam int DEBOUNCE_CYC  = CLK_HZ / 1000000 * DEBOUNCE_US;
	localparam int TENTH_S_CYC   = CLK_HZ / 10;
	localparam int SLEW_BASE_CYC = CLK_HZ;
	localparam int RAMP_TICK_CYC = CLK_HZ / 1000;
	typedef enum logic [1:0] {TRC_IDLE, TRC_WAIT, TRC_RUN, TRC_DECEL} trc_state_t;
endpackage

// File: rtl/trc_term_if.sv
// debounced terminal levels and closing edges passed to the control core
`timescale 1ns/10ps
interface trc_term_if;
	logic level;
	logic closed;
	modport filt (output level, output closed);
	modport core (input level, input closed);
endinterface

// File: rtl/trc_top.sv
// terminal run command control: mode decode, stop, up/down and an autorun wait that is never entered
`timescale 1ns/10ps
module trc_top
	import trc_pkg::*;
#(
	parameter int DEB_CYC   = DEBOUNCE_CYC,
	parameter int TENTH_CYC = TENTH_S_CYC,
	parameter int SLEW_CYC  = SLEW_BASE_CYC,
	parameter int RAMP_CYC  = RAMP_TICK_CYC
) (
	// clock, reset, enable
	input  wire logic          clk_in,
	input  wire logic          rst_in,
	input  wire logic          ce_in,
	// AHB-Lite slave
	input  wire logic          hsel_in,
	input  wire logic [31:0]   haddr_in,
	input  wire logic [1:0]    htrans_in,
	input  wire logic          hwrite_in,
	input  wire logic [2:0]    hsize_in,
	input  wire logic [31:0]   hwdata_in,
	input  wire logic          hready_in,
	output logic      [31:0]   hrdata_out,
	output logic               hreadyout_out,
	output logic               hresp_out,
	// terminals, high when closed
	input  wire logic          forward_terminal_in,
	input  wire logic          backward_terminal_in,
	input  wire logic          hold_enable_in,
	input  wire logic          up_terminal_in,
	input  wire logic          down_terminal_in,
	// stage ramp time from the stage speed logic, in ms per 0.01 Hz
	input  wire logic [15:0]   stage_ramp_in,
	input  wire logic [15:0]   general_accel_time_in,
	input  wire logic [15:0]   general_decel_time_in,
	// drive outputs
	output logic               run_out,
	output logic               reverse_out,
	output logic               output_enable_out,
	output logic      [15:0]   frequency_out
);
	trc_term_if t_fwd ();
	trc_term_if t_bwd ();
	trc_term_if t_hold ();
	trc_term_if t_up ();
	trc_term_if t_dn ();

	trc_debounce #(.CNT(DEB_CYC)) u_fwd (.clk_in(clk_in), .rst_in(rst_in),
		.ce_in(ce_in), .raw_in(forward_terminal_in), .term(t_fwd));
	trc_debounce #(.CNT(DEB_CYC)) u_bwd (.clk_in(clk_in), .rst_in(rst_in),
		.ce_in(ce_in), .raw_in(backward_terminal_in), .term(t_bwd));
	trc_debounce #(.CNT(DEB_CYC)) u_hold (.clk_in(clk_in), .rst_in(rst_in),
		.ce_in(ce_in), .raw_in(hold_enable_in), .term(t_hold));
	trc_debounce #(.CNT(DEB_CYC)) u_up (.clk_in(clk_in), .rst_in(rst_in),
		.ce_in(ce_in), .raw_in(up_terminal_in), .term(t_up));
	trc_debounce #(.CNT(DEB_CYC)) u_dn (.clk_in(clk_in), .rst_in(rst_in),
		.ce_in(ce_in), .raw_in(down_terminal_in), .term(t_dn));

	// configuration registers
	logic [2:0]  terminal_run_mode_select;
	logic        stop_method_select;
	logic [15:0] updown_step_size;
	logic [15:0] updown_slew_rate;
	logic        direction_memory_enable;
	logic        powerup_autorun_enable;
	logic        frequency_retain_enable;
	logic        stage_speed_active;
	logic [15:0] autorun_delay;
	logic [15:0] preset_target_frequency;
	logic [3:0]  keypad_cmd;
	// saved-state (retained across power loss by the host system)
	logic [15:0] saved_freq;
	logic        saved_run;
	logic        saved_dir;

	// bus address phase capture
	logic        dp_wr;
	logic [7:0]  dp_addr;
	wire         ap_valid = hsel_in && htrans_in[1] && hready_in;
	wire         wr_now = dp_wr && ce_in;
	wire  [15:0] wd16 = hwdata_in[15:0];

	// clamp written step, slew and delay values into their legal ranges; an out-of-range mode becomes MODE_OFF
	wire  [15:0] step_cl  = wd16 < STEP_MIN ? STEP_MIN :
	                        wd16 > STEP_MAX ? STEP_MAX : wd16;
	wire  [15:0] slew_cl  = wd16 < SLEW_MIN ? SLEW_MIN :
	                        wd16 > SLEW_MAX ? SLEW_MAX : wd16;
	wire  [15:0] delay_cl = wd16 < DELAY_MIN ? DELAY_MIN :
	                        wd16 > DELAY_MAX ? DELAY_MAX : wd16;
	wire  [2:0]  mode_cl  = hwdata_in[2:0] > MODE_PULSE ? MODE_OFF
	                        : hwdata_in[2:0];

	// core state
	trc_state_t  state;
	trc_state_t  next_state;
	logic        dir;
	logic        dir_mem;
	logic [15:0] target;
	logic [23:0] delay_cnt;
	logic [15:0] tenths;
	logic [31:0] slew_acc;
	logic [23:0] ramp_cnt;
	logic        key_run_q;

	wire running = state == TRC_RUN;
	wire wait_auto = state == TRC_WAIT;

	// terminal command decode, combinational per mode
	wire fl = t_fwd.level;
	wire bl = t_bwd.level;
	wire hl = t_hold.level;
	wire fe = t_fwd.closed;
	wire be = t_bwd.closed;
	wire term_mode = terminal_run_mode_select != MODE_OFF;
	wire in_3l = terminal_run_mode_select == MODE_3L1 ||
	             terminal_run_mode_select == MODE_3L2;
	wire key_start = keypad_cmd[KEY_RUN] && !key_run_q;
	wire key_stop  = !keypad_cmd[KEY_RUN] && key_run_q;

	logic cmd_start;
	logic cmd_stop;
	logic cmd_dir;
	logic cmd_dir_given;
	always_comb begin
		cmd_start = 1'b0;
		cmd_stop = 1'b0;
		cmd_dir = dir;
		cmd_dir_given = 1'b1;
		case (terminal_run_mode_select)
			MODE_OFF: begin
				cmd_start = key_start;
				cmd_stop = key_stop;
				cmd_dir = keypad_cmd[KEY_DIR];
			end
			MODE_2L1: begin
				cmd_start = fl ^ bl;
				cmd_stop = fl == bl;
				cmd_dir = bl;
			end
			MODE_2L2: begin
				cmd_start = fl;
				cmd_stop = !fl;
				cmd_dir = bl;
			end
			MODE_3L1: begin
				cmd_start = hl && (fe || be);
				cmd_stop = !hl;
				cmd_dir_given = fe || be;
				cmd_dir = be && !fe;
				if (fe && be && direction_memory_enable) begin
					cmd_dir_given = 1'b0;
				end
			end
			MODE_3L2: begin
				cmd_start = hl && fe;
				cmd_stop = !hl;
				cmd_dir = bl;
			end
			MODE_PULSE: begin
				cmd_start = !running && (fe || be);
				cmd_stop = running && (fe || be);
				cmd_dir = be && !fe;
			end
			default: begin
				cmd_stop = 1'b1;
			end
		endcase
	end

	// direction memory only counts in three-line mode one
	wire use_mem = direction_memory_enable &&
	               terminal_run_mode_select == MODE_3L1;
	wire start_dir = (!cmd_dir_given && use_mem) ? dir_mem : cmd_dir;

	// ramp tick period: stage time under stage speed, else general
	wire [15:0] ramp_ms = stage_speed_active ? stage_ramp_in :
	              (state == TRC_DECEL || target < frequency_out)
	              ? general_decel_time_in : general_accel_time_in;
	wire ramp_tick = ramp_cnt >= 24'(RAMP_CYC) * {8'h00, ramp_ms};
	wire at_zero = frequency_out == 16'h0000;

	// up/down handling
	wire [15:0] press_step = running ? updown_step_size
	                         : STANDBY_STEP;
	wire held = (t_up.level ^ t_dn.level) && !t_up.closed && !t_dn.closed;
	wire [31:0] slew_next = slew_acc + {16'h0000, updown_slew_rate};
	wire slew_tick = held && slew_next >= 32'(SLEW_CYC);
	wire [16:0] tgt_up = {1'b0, target} +
	              {1'b0, t_up.closed ? press_step : RAMP_STEP};
	wire [15:0] tgt_dn_sub = t_dn.closed ? press_step : RAMP_STEP;
	wire [15:0] tgt_dn = target > tgt_dn_sub ? target - tgt_dn_sub : 16'h0000;
	wire inc = t_up.closed || (slew_tick && t_up.level);
	wire dec = t_dn.closed || (slew_tick && t_dn.level);

	// autorun delay counting in tenths of a second
	wire tenth_tick = delay_cnt == 24'(TENTH_CYC - 1);
	wire delay_done = tenths >= autorun_delay;

	always_comb begin
		next_state = state;
		case (state)
			TRC_IDLE: if (cmd_start && !cmd_stop) begin
				next_state = TRC_RUN;
			end
			TRC_WAIT: if (cmd_stop && term_mode) begin
				next_state = TRC_IDLE;
			end else if (delay_done) begin
				next_state = TRC_RUN;
			end
			TRC_RUN: if (cmd_stop) begin
				next_state = stop_method_select == STOP_COAST
				             ? TRC_IDLE : TRC_DECEL;
			end
			TRC_DECEL: if (cmd_start && !cmd_stop) begin
				next_state = TRC_RUN;
			end else if (at_zero) begin
				next_state = TRC_IDLE;
			end
			default: next_state = TRC_IDLE;
		endcase
	end

	// reset stands for power return; powerup_autorun_enable is still reset here, so we always land in TRC_IDLE
	logic boot;
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			boot <= 1'b1;
			state <= TRC_IDLE;
			dir <= 1'b0;
			dir_mem <= 1'b0;
			target <= PRESET_RST;
			frequency_out <= 16'h0000;
			delay_cnt <= '0;
			tenths <= '0;
			slew_acc <= '0;
			ramp_cnt <= '0;
			key_run_q <= 1'b0;
			run_out <= 1'b0;
			reverse_out <= 1'b0;
			output_enable_out <= 1'b0;
		end else if (ce_in) begin
			boot <= 1'b0;
			key_run_q <= keypad_cmd[KEY_RUN];
			if (boot) begin
				state <= powerup_autorun_enable && saved_run
				         ? TRC_WAIT : TRC_IDLE;
				dir <= saved_dir;
				target <= frequency_retain_enable ? saved_freq
				          : preset_target_frequency;
			end else begin
				state <= next_state;
				if (state != TRC_RUN && next_state == TRC_RUN &&
				    state != TRC_WAIT) begin
					dir <= start_dir;
				end else if (running && (terminal_run_mode_select == MODE_2L1
				             || terminal_run_mode_select == MODE_2L2)) begin
					dir <= cmd_dir;
				end
				if (next_state == TRC_RUN && use_mem) begin
					dir_mem <= next_state == state ? dir : start_dir;
				end else if (!use_mem) begin
					dir_mem <= 1'b0;
				end
				if (inc) begin
					target <= tgt_up[16] ? 16'hFFFF : tgt_up[15:0];
				end else if (dec) begin
					target <= tgt_dn;
				end
				slew_acc <= !held ? 32'h0 : slew_tick
				            ? slew_next - 32'(SLEW_CYC) : slew_next;
				delay_cnt <= wait_auto && !tenth_tick ? delay_cnt + 24'h1 : '0;
				tenths <= !wait_auto ? 16'h0 : tenth_tick
				          ? tenths + 16'h0001 : tenths;
				ramp_cnt <= ramp_tick ? '0 : ramp_cnt + 24'h000001;
				if (next_state == TRC_IDLE || next_state == TRC_WAIT) begin
					frequency_out <= 16'h0000;
				end else if (ramp_tick) begin
					if (state == TRC_DECEL) begin
						frequency_out <= at_zero ? 16'h0000
						                 : frequency_out - RAMP_STEP;
					end else if (frequency_out < target) begin
						frequency_out <= frequency_out + RAMP_STEP;
					end else if (frequency_out > target) begin
						frequency_out <= frequency_out - RAMP_STEP;
					end
				end
			end
			run_out <= next_state == TRC_RUN || next_state == TRC_DECEL;
			output_enable_out <= next_state == TRC_RUN ||
			                     next_state == TRC_DECEL;
			reverse_out <= dir;
		end
	end

	// AHB-Lite slave: zero wait states, always OKAY
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			dp_wr <= 1'b0;
			dp_addr <= 8'h00;
			hreadyout_out <= 1'b1;
			hresp_out <= 1'b0;
			hrdata_out <= 32'h0;
			terminal_run_mode_select <= MODE_OFF;
			stop_method_select <= STOP_RAMP;
			updown_step_size <= STEP_RST;
			updown_slew_rate <= SLEW_RST;
			direction_memory_enable <= 1'b0;
			powerup_autorun_enable <= 1'b0;
			frequency_retain_enable <= 1'b0;
			stage_speed_active <= 1'b0;
			autorun_delay <= DELAY_RST;
			preset_target_frequency <= PRESET_RST;
			keypad_cmd <= 4'h0;
			saved_freq <= 16'h0;
			saved_run <= 1'b0;
			saved_dir <= 1'b0;
		end else if (ce_in) begin
			dp_wr <= ap_valid && hwrite_in;
			dp_addr <= haddr_in[7:0];
			if (wr_now) begin
				case (dp_addr)
					OFS_MODE:   terminal_run_mode_select <= mode_cl;
					OFS_STOPM:  stop_method_select <= hwdata_in[0];
					OFS_STEP:   updown_step_size <= step_cl;
					OFS_SLEW:   updown_slew_rate <= slew_cl;
					OFS_FLAGS: begin
						direction_memory_enable <= hwdata_in[FLG_DIRMEM];
						powerup_autorun_enable <= hwdata_in[FLG_AUTORUN];
						frequency_retain_enable <= hwdata_in[FLG_RETAIN];
						stage_speed_active <= hwdata_in[FLG_STAGE];
					end
					OFS_DELAY:  autorun_delay <= delay_cl;
					OFS_PRESET: preset_target_frequency <= wd16;
					OFS_KEYPAD: keypad_cmd <= hwdata_in[3:0];
					OFS_SAVED: begin
						saved_freq <= wd16;
						saved_run <= hwdata_in[16];
						saved_dir <= hwdata_in[17];
					end
					default: ;
				endcase
			end
			// keypad run sources carry no weight once terminals rule
			if (term_mode && !(wr_now && dp_addr == OFS_KEYPAD)) begin
				keypad_cmd[KEY_RUN] <= 1'b0;
			end
			hrdata_out <= 32'h0;
			if (ap_valid && !hwrite_in) begin
				case (haddr_in[7:0])
					OFS_MODE:   hrdata_out <= {29'h0, terminal_run_mode_select};
					OFS_STOPM:  hrdata_out <= {31'h0, stop_method_select};
					OFS_STEP:   hrdata_out <= {16'h0, updown_step_size};
					OFS_SLEW:   hrdata_out <= {16'h0, updown_slew_rate};
					OFS_FLAGS:  hrdata_out <= {28'h0, stage_speed_active,
					                frequency_retain_enable,
					                powerup_autorun_enable,
					                direction_memory_enable};
					OFS_DELAY:  hrdata_out <= {16'h0, autorun_delay};
					OFS_PRESET: hrdata_out <= {16'h0, preset_target_frequency};
					OFS_KEYPAD: hrdata_out <= {28'h0, keypad_cmd};
					OFS_STATUS: hrdata_out <= {28'h0, wait_auto,
					                output_enable_out, dir, run_out};
					OFS_FREQ:   hrdata_out <= {target, frequency_out};
					OFS_SAVED:  hrdata_out <= {14'h0, dir, run_out,
					                frequency_out};
					default:    hrdata_out <= 32'h0;
				endcase
			end
		end
	end
endmodule

// File: test/terminal_run_command_control_tb_top.sv
// self-checking bench for the terminal run command control
`timescale 1ns/10ps
module terminal_run_command_control_tb_top;
	import trc_pkg::*;
	logic        clk_in;
	logic        rst_in;
	logic        hsel;
	logic        hwrite;
	logic        hready;
	logic        hresp;
	logic        bounce;
	logic        ce;
	logic [2:0]  hsize;
	logic [15:0] stage_ramp;
	logic [15:0] accel;
	logic [15:0] decel;
	logic [31:0] rd_q;
	logic        run;
	logic        backward_terminal;
	logic        oe;
	logic [1:0]  htrans;
	logic [4:0]  want;
	logic [4:0]  term;
	logic [15:0] freq;
	logic [31:0] haddr;
	logic [31:0] hwdata;
	logic [31:0] hrdata;
	logic [1:0]  tbl [2][4] = '{'{2'h0, 2'h2, 2'h3, 2'h0},
		'{2'h0, 2'h2, 2'h0, 2'h3}};
	int          num_errors = 0;
	int          samples_checked = 0;

	trc_switch_model sw (
		.clk_in      (clk_in),
		.want_in     (want),
		.bounce_in   (bounce),
		.contact_out (term)
	);
	trc_top #(.DEB_CYC(4), .TENTH_CYC(10), .SLEW_CYC(1000), .RAMP_CYC(2)) dut (
		.clk_in                (clk_in),
		.rst_in                (rst_in),
		.ce_in                 (ce),
		.hsel_in               (hsel),
		.haddr_in              (haddr),
		.htrans_in             (htrans),
		.hwrite_in             (hwrite),
		.hsize_in              (hsize),
		.hwdata_in             (hwdata),
		.hready_in             (hready),
		.hrdata_out            (hrdata),
		.hreadyout_out         (hready),
		.hresp_out             (hresp),
		.forward_terminal_in   (term[0]),
		.backward_terminal_in  (term[1]),
		.hold_enable_in        (term[2]),
		.up_terminal_in        (term[3]),
		.down_terminal_in      (term[4]),
		.stage_ramp_in         (stage_ramp),
		.general_accel_time_in (accel),
		.general_decel_time_in (decel),
		.run_out               (run),
		.reverse_out           (backward_terminal),
		.output_enable_out     (oe),
		.frequency_out         (freq)
	);

	task automatic end_of_test;
		if (num_errors == 0 && samples_checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic check(string n, logic [31:0] seen, logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("FAIL %s expected %h seen %h", n, exp, seen);
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h000000, a};
		do @(posedge clk_in); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk_in); while (hready !== 1'b1);
		q = hrdata;
	endtask
	task automatic wr(logic [7:0] a, logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask
	task automatic rd_chk(string n, logic [7:0] a, logic [31:0] e);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, q);
		check(n, q, e);
	endtask
	// settle time covers sync, debounce, decode and output flop
	task automatic term_set(logic [4:0] v);
		want <= v;
		repeat (14) @(posedge clk_in);
	endtask
	task automatic pulse(logic [4:0] m);
		term_set(want ^ m);
		term_set(want ^ m);
	endtask
	task automatic outs(string n, logic [1:0] e);
		check(n, {30'h0, run, run & backward_terminal}, {30'h0, e});
	endtask

	initial begin
		clk_in = 1'b0;
		forever #25 clk_in = ~clk_in;
	end
	initial begin
		repeat (20000) @(posedge clk_in);
		num_errors++;
		end_of_test();
	end
	initial begin
		rst_in = 1'b1;
		hsel = 1'b0;
		hwrite = 1'b0;
		htrans = 2'h0;
		haddr = 32'h0;
		hwdata = 32'h0;
		want = 5'h00;
		bounce = 1'b0;
		ce = 1'b1;
		hsize = 3'h2;
		stage_ramp = 16'h0000;
		accel = 16'h0000;
		decel = 16'h0000;
		repeat (4) @(posedge clk_in);
		rst_in <= 1'b0;
		rd_chk("mode", OFS_MODE, 32'h0);
		rd_chk("step", OFS_STEP, STEP_RST);
		rd_chk("slew", OFS_SLEW, SLEW_RST);
		rd_chk("delay", OFS_DELAY, DELAY_RST);
		rd_chk("hole", 8'h40, 32'h0);
		outs("boot", 2'h0);
		wr(OFS_MODE, 32'h6);
		rd_chk("bad_mode", OFS_MODE, 32'h0);
		wr(OFS_DELAY, 32'h0);
		rd_chk("delay_lo", OFS_DELAY, DELAY_MIN);
		wr(OFS_DELAY, 32'hFFFF);
		rd_chk("delay_hi", OFS_DELAY, DELAY_MAX);
		wr(OFS_STEP, 32'h300);
		rd_chk("step_hi", OFS_STEP, STEP_MAX);
		// a write made while the enable is low must not land
		ce <= 1'b0;
		wr(OFS_STEP, 32'h5);
		ce <= 1'b1;
		rd_chk("frozen", OFS_STEP, STEP_MAX);
		wr(OFS_PRESET, 32'h28);
		wr(OFS_STOPM, STOP_COAST);
		term_set(5'h01);
		outs("mode_off", 2'h0);
		term_set(5'h00);
		// keypad run stays ignored while terminal modes are used
		wr(OFS_MODE, MODE_2L1);
		wr(OFS_KEYPAD, 32'h1);
		repeat (14) @(posedge clk_in);
		outs("keypad", 2'h0);
		wr(OFS_KEYPAD, 32'h0);
		for (int m = 0; m < 2; m++) begin
			wr(OFS_MODE, m + 1);
			bounce <= m[0];
			for (int i = 0; i < 4; i++) begin
				term_set(i[4:0]);
				outs("two_line", tbl[m][i]);
				term_set(5'h00);
				check("coast", oe, 1'b0);
			end
		end
		wr(OFS_MODE, MODE_3L1);
		// memory on so the reverse run below is the one remembered
		wr(OFS_FLAGS, 32'h1);
		term_set(5'h04);
		pulse(5'h02);
		outs("three_a", 2'h3);
		term_set(5'h00);
		outs("hold_a", 2'h0);
		term_set(5'h04);
		pulse(5'h03);
		outs("memory", 2'h3);
		term_set(5'h00);
		wr(OFS_FLAGS, 32'h0);
		wr(OFS_MODE, MODE_3L2);
		term_set(5'h06);
		pulse(5'h01);
		outs("three_b", 2'h3);
		term_set(5'h02);
		outs("hold_b", 2'h0);
		term_set(5'h00);
		wr(OFS_MODE, MODE_PULSE);
		for (int i = 0; i < 4; i++) begin
			pulse(i[1] ? 5'h02 : 5'h01);
			outs("toggle", i[0] ? 2'h0 : {1'b1, i[1]});
		end
		wr(OFS_MODE, MODE_2L1);
		wr(OFS_STOPM, STOP_RAMP);
		// zero ramp time steps once a cycle from the edge that starts the run
		want <= 5'h01;
		wait (run === 1'b1);
		repeat (40) @(posedge clk_in);
		check("speed", freq, 16'h0028);
		want <= 5'h00;
		repeat (10) @(posedge clk_in);
		outs("ramp_on", 2'h2);
		repeat (100) @(posedge clk_in);
		outs("ramp_end", 2'h0);
		check("ramp_zero", freq, 16'h0);
		wr(OFS_STEP, 32'h32);
		wr(OFS_SLEW, 32'h1);
		pulse(5'h08);
		// target is loaded from the preset at power return only
		rd_chk("standby_up", OFS_FREQ,
			{PRESET_RST + STANDBY_STEP, 16'h0000});
		term_set(5'h01);
		repeat (100) @(posedge clk_in);
		pulse(5'h08);
		bus(1'b0, OFS_FREQ, 32'h0, rd_q);
		check("running_up", {16'h0000, rd_q[31:16]},
			{16'h0000, PRESET_RST + STANDBY_STEP + 16'h0032});
		term_set(5'h00);
		end_of_test();
	end
endmodule

// File: test/trc_switch_model.sv
// operator switches and pushbuttons, with optional contact bounce
`timescale 1ns/10ps
module trc_switch_model (
	// control from the bench
	input  wire logic       clk_in,
	input  wire logic [4:0] want_in,
	input  wire logic       bounce_in,
	// contacts, high when closed
	output logic      [4:0] contact_out
);
	logic [4:0] last;
	logic [4:0] prev;
	logic [1:0] left;
	initial begin
		last = 5'h00;
		prev = 5'h00;
		left = 2'h0;
	end
	// a bouncing contact flips back to its old level twice, one cycle each
	assign contact_out = left[0] ? prev : last;
	always @(posedge clk_in) begin
		if (want_in != last) begin
			prev <= last;
			left <= bounce_in ? 2'h3 : 2'h0;
		end else if (left != 2'h0)
			left <= left - 2'h1;
		last <= want_in;
	end
endmodule

// File: test/trc_top_monitor.sv
// concurrent checks on the ports of the run command control
`timescale 1ns/10ps
module trc_check #(
	parameter int DEB_CYC = 4
) (
	input wire logic        clk_in,
	input wire logic        rst_in,
	input wire logic        ce_in,
	input wire logic        hsel_in,
	input wire logic [1:0]  htrans_in,
	input wire logic        hwrite_in,
	input wire logic        hready_in,
	input wire logic [31:0] hrdata_out,
	input wire logic        hreadyout_out,
	input wire logic        hresp_out,
	input wire logic        forward_terminal_in,
	input wire logic        backward_terminal_in,
	input wire logic        run_out,
	input wire logic        output_enable_out,
	input wire logic [15:0] frequency_out
);
	logic [7:0] term_cnt;
	// cycles that a start terminal has stayed closed
	always_ff @(posedge clk_in) begin
		if (rst_in || !(forward_terminal_in || backward_terminal_in))
			term_cnt <= 8'h00;
		else if (term_cnt != 8'hFF)
			term_cnt <= term_cnt + 8'h01;
	end
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (rst_in);
	sequence s_released;
		$fell(rst_in);
	endsequence
	sequence s_held_off;
		!run_out [*8];
	endsequence
	a_ready_high: assert property (hreadyout_out)
		else $error("ready low");
	a_resp_okay: assert property (!hresp_out)
		else $error("error response");
	a_rdata_idle: assert property (
		!$past(hsel_in && htrans_in[1] && !hwrite_in && hready_in && ce_in)
		|-> hrdata_out == 32'h0)
		else $error("read data outside read");
	a_boot_stopped: assert property (s_released |-> s_held_off)
		else $error("ran after power return");
	a_start_held: assert property (
		$rose(run_out) |-> term_cnt >= DEB_CYC)
		else $error("start without settled terminal");
	a_off_no_drive: assert property (!run_out |-> !output_enable_out)
		else $error("output on while stopped");
	a_stop_zero: assert property (
		$fell(run_out) |-> frequency_out == 16'h0 || !output_enable_out)
		else $error("run ended above zero");
	a_freq_slews: assert property (
		output_enable_out && $past(output_enable_out) |->
		frequency_out == $past(frequency_out) ||
		frequency_out == $past(frequency_out) + 16'h0001 ||
		frequency_out == $past(frequency_out) - 16'h0001)
		else $error("frequency jumped");
endmodule

bind trc_top trc_check #(.DEB_CYC(DEB_CYC)) mon (
	.clk_in               (clk_in),
	.rst_in               (rst_in),
	.ce_in                (ce_in),
	.hsel_in              (hsel_in),
	.htrans_in            (htrans_in),
	.hwrite_in            (hwrite_in),
	.hready_in            (hready_in),
	.hrdata_out           (hrdata_out),
	.hreadyout_out        (hreadyout_out),
	.hresp_out            (hresp_out),
	.forward_terminal_in  (forward_terminal_in),
	.backward_terminal_in (backward_terminal_in),
	.run_out              (run_out),
	.output_enable_out    (output_enable_out),
	.frequency_out        (frequency_out)
);
